// [kbd_params.svh]
`ifndef KBD_PARAMS_SVH
`define KBD_PARAMS_SVH
// Functional notes
// - Return lines are active low, idle high.
// - Strobed mode takes return lines as byte.
// - Interrupt high while FIFO holds entries, outside sensor mode.
// - Data read drops interrupt, reraises if nonempty.
// - End-interrupt command clears interrupt output.
// - Reset: 16 digit, left, encoded, lockout, 31.
// - Reset leaves display RAM contents intact.
// - Select high: command/status; low: data.
// - Bus accesses only while chip select low.
// - Blank output during digit switching, command forces low.
// - Display ports follow RAM with scan while read FIFO is set.
// - Ports blank independently, clear picks level.
// - Scan outputs decoded or encoded per mode.
// - Scan outputs low while reset asserted.
// - Keyboard mode stores shift as bit six.
// - Keyboard mode stores control as bit seven.
// - Strobed mode writes word on control rise.
// - Sensor mode ignores control input.
// - Debounce buffer and eight byte FIFO.
// - Sixteen byte display RAM, eight digit option.
// - Exactly one input mode at a time.
// - Commands latched on write strobe rise.
// - Read FIFO command persists for data reads.
`define CMD_MODE 3'h0
`define CMD_CLOCK 3'h1
`define CMD_RDFIFO 3'h2
`define CMD_RDDISP 3'h3
`define CMD_WRDISP 3'h4
`define CMD_INHBL 3'h5
`define CMD_CLEAR 3'h6
`define CMD_ENDINT 3'h7
`define RST_DISP_MODE 2'h1
`define RST_KEY_MODE 3'h0
`define RST_PRESCALE 5'h1f
`define MIN_PRESCALE 5'h02
`define SCAN_DWELL 8'h40
`define BLANK_CYCLES 8'h04
`endif

// [kbd_pkg.sv]
package kbd_pkg;
  typedef enum logic [1:0]
  {
    IN_KEYBOARD = 2'h0,
    IN_SENSOR = 2'h1,
    IN_STROBED = 2'h3
  } input_mode_type;
  typedef struct packed
  {
    logic [7:0] data;
    logic sel;
    logic cs_n;
  } bus_req_type;
  typedef struct packed
  {
    logic [3:0] a;
    logic [3:0] b;
  } disp_out_type;
endpackage : kbd_pkg

// [kbd_ram.sv]
`timescale 1ns/1ps
// Small synchronous RAM with a registered read port.
module kbd_ram #(parameter int DW = 8, parameter int AW = 4)
(
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // Contents carry no reset, so a reset never wipes them.
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule : kbd_ram

// [kbd_scanner.sv]
`timescale 1ns/1ps
`include "kbd_params.svh"
// Keyboard/display scanner core with host port on plain pins.
module kbd_scanner #(parameter int FIFO_DEPTH = 8)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic CONTROL_DATA_SELECT,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic IRQ,
  input wire logic [7:0] RETURN_LINES,
  input wire logic SHIFT_INPUT,
  input wire logic CONTROL_STROBE_INPUT,
  output logic [3:0] SCAN_OUTPUTS,
  output logic [3:0] DISPLAY_PORT_A,
  output logic [3:0] DISPLAY_PORT_B,
  output logic BLANKING_OUTPUT_N
);
  initial
  begin
    if (FIFO_DEPTH != 8)
      $error("FIFO depth must be eight");
  end
  logic [1:0] rd_sync_q, wr_sync_q;
  logic rd_prev_q, wr_prev_q;
  kbd_pkg::bus_req_type req;
  logic rd_start, wr_end;
  logic [1:0] disp_mode_q;
  logic [2:0] key_mode_q;
  logic [4:0] prescale_q;
  logic rd_fifo_q, ai_q;
  logic [3:0] daddr_q;
  logic [1:0] inhibit_q, blank_q;
  logic [7:0] clear_val_q;
  logic [7:0] fifo_q [0:7];
  logic [2:0] fifo_rp_q, fifo_wp_q;
  logic [3:0] fifo_cnt_q;
  logic [4:0] pre_cnt_q;
  logic [7:0] dwell_q;
  logic [3:0] scan_q;
  logic [7:0] debounce_q;
  logic [7:0] held_q;
  logic control_strobe_input_prev_q;
  logic irq_q;
  logic endint_q;
  logic is_cmd, is_data;
  logic [2:0] cmd;
  logic [7:0] disp_rdata, disp_wdata, dram_wdata;
  logic disp_we, dram_we;
  logic [3:0] dram_waddr, scan_addr;
  logic [7:0] ret_act;
  logic key_push, strobe_push, fifo_pop, fifo_push;
  logic [7:0] push_data;
  logic sensor_mode, strobe_mode, key_mode;
  logic [4:0] eff_pre;
  logic tick, scan_step;
  logic [7:0] status;
  // The strobes are asynchronous to CLK, so two flops come first.
  always_ff @(posedge CLK)
  begin
    rd_sync_q <= {rd_sync_q[0], RD_N};
    wr_sync_q <= {wr_sync_q[0], WR_N};
    rd_prev_q <= rd_sync_q[1];
    wr_prev_q <= wr_sync_q[1];
  end
  assign req = '{data: DATA_IN, sel: CONTROL_DATA_SELECT, cs_n: CS_N};
  // Access only counts while chip select is low.
  assign rd_start = rd_prev_q & ~rd_sync_q[1] & ~req.cs_n;
  assign wr_end = ~wr_prev_q & wr_sync_q[1] & ~req.cs_n;
  assign is_cmd = wr_end & req.sel;
  assign is_data = wr_end & ~req.sel;
  assign cmd = req.data[7:5];
  // One input mode from key mode field.
  assign sensor_mode = key_mode_q[2:1] == 2'b10;
  assign strobe_mode = key_mode_q[2:1] == 2'b11;
  assign key_mode = ~key_mode_q[2];
  assign eff_pre = (prescale_q < `MIN_PRESCALE) ? `MIN_PRESCALE : prescale_q;
  assign tick = pre_cnt_q >= eff_pre - 5'h01;
  assign scan_step = tick & (dwell_q == `SCAN_DWELL);
  // Eight digit mode wraps the scan at eight.
  assign scan_addr = disp_mode_q[0] ? scan_q : {1'b0, scan_q[2:0]};
  assign ret_act = ~RETURN_LINES;
  // Key code: control, shift, scan row, column.
  logic [2:0] col;
  always_comb
  begin
    col = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (ret_act[i])
        col = 3'(i);
  end
  assign key_push = key_mode & scan_step & (ret_act != 8'h00)
    & debounce_q[scan_q[2:0]] & ~held_q[scan_q[2:0]];
  // Strobed entry writes on control rising edge.
  assign strobe_push = strobe_mode & CONTROL_STROBE_INPUT & ~control_strobe_input_prev_q;
  assign push_data = strobe_mode ? RETURN_LINES
    : sensor_mode ? ret_act
    : {CONTROL_STROBE_INPUT, SHIFT_INPUT, scan_q[2:0], col};
  assign fifo_push = (key_push | strobe_push) & (fifo_cnt_q != 4'h8);
  assign fifo_pop = rd_start & ~req.sel & rd_fifo_q & (fifo_cnt_q != 4'h0);
  // Display RAM write through the host data path only.
  assign disp_wdata = {inhibit_q[1] ? disp_rdata[7:4] : req.data[7:4],
    inhibit_q[0] ? disp_rdata[3:0] : req.data[3:0]};
  assign disp_we = is_data;
  assign dram_we = disp_we;
  assign dram_waddr = daddr_q;
  assign dram_wdata = disp_wdata;
  kbd_ram #(.DW(8), .AW(4)) u_disp
  (
    .clk(CLK),
    .we(dram_we),
    .waddr(dram_waddr),
    .wdata(dram_wdata),
    .raddr(rd_fifo_q ? scan_addr : daddr_q),
    .rdata(disp_rdata)
  );
  assign status = {2'b00, 1'b0, 1'b0, fifo_cnt_q[3], fifo_cnt_q[2:0]};
  // Command decode; reset gives the documented defaults.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      disp_mode_q <= `RST_DISP_MODE;
      key_mode_q <= `RST_KEY_MODE;
      prescale_q <= `RST_PRESCALE;
      rd_fifo_q <= 1'b1;
      ai_q <= 1'b0;
      daddr_q <= 4'h0;
      inhibit_q <= 2'b00;
      blank_q <= 2'b00;
      clear_val_q <= 8'h00;
    end
    else if (is_cmd)
    begin
      case (cmd)
        `CMD_MODE:
        begin
          disp_mode_q <= req.data[4:3];
          key_mode_q <= req.data[2:0];
        end
        `CMD_CLOCK: prescale_q <= req.data[4:0];
        `CMD_RDFIFO: rd_fifo_q <= 1'b1;
        `CMD_RDDISP:
        begin
          rd_fifo_q <= 1'b0;
          ai_q <= req.data[4];
          daddr_q <= req.data[3:0];
        end
        `CMD_WRDISP:
        begin
          ai_q <= req.data[4];
          daddr_q <= req.data[3:0];
        end
        `CMD_INHBL:
        begin
          inhibit_q <= req.data[3:2];
          blank_q <= req.data[1:0];
        end
        // Clear picks the blanking level.
        `CMD_CLEAR:
          clear_val_q <= req.data[3] ? (req.data[2] ? 8'hff : 8'h20)
            : 8'h00;
        default: ;
      endcase
    end
    else if ((is_data | (rd_start & ~req.sel & ~rd_fifo_q)) & ai_q)
      daddr_q <= daddr_q + 4'h1;
  end
  // FIFO storage; no reset on the data words.
  always_ff @(posedge CLK)
  begin
    if (fifo_push)
      fifo_q[fifo_wp_q] <= push_data;
  end
  // Pointers, FIFO count and debounce state.
  always_ff @(posedge CLK)
  begin
    if (RESET | (is_cmd & (cmd == `CMD_CLEAR) & req.data[1]))
    begin
      fifo_rp_q <= 3'h0;
      fifo_wp_q <= 3'h0;
      fifo_cnt_q <= 4'h0;
      debounce_q <= 8'h00;
      held_q <= 8'h00;
    end
    else
    begin
      if (fifo_push)
        fifo_wp_q <= fifo_wp_q + 3'h1;
      if (fifo_pop)
        fifo_rp_q <= fifo_rp_q + 3'h1;
      fifo_cnt_q <= fifo_cnt_q + {3'h0, fifo_push} - {3'h0, fifo_pop};
      if (scan_step & key_mode)
      begin
        debounce_q[scan_q[2:0]] <= ret_act != 8'h00;
        held_q[scan_q[2:0]] <= debounce_q[scan_q[2:0]] & (ret_act != 8'h00);
      end
    end
  end
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pre_cnt_q <= 5'h00;
      dwell_q <= 8'h00;
      scan_q <= 4'h0;
      control_strobe_input_prev_q <= 1'b1;
    end
    else
    begin
      control_strobe_input_prev_q <= CONTROL_STROBE_INPUT;
      pre_cnt_q <= tick ? 5'h00 : pre_cnt_q + 5'h01;
      if (tick)
        dwell_q <= (dwell_q == `SCAN_DWELL) ? 8'h00 : dwell_q + 8'h01;
      if (scan_step)
        scan_q <= scan_q + 4'h1;
    end
  end
  // Interrupt follows FIFO level outside sensor mode; a data read drops it one cycle.
  // End-interrupt holds the request low until the next push or data read,
  // otherwise a nonempty FIFO would raise it again at once.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      irq_q <= 1'b0;
      endint_q <= 1'b0;
    end
    else if (is_cmd & (cmd == `CMD_ENDINT))
    begin
      irq_q <= 1'b0;
      endint_q <= 1'b1;
    end
    else if (rd_start & ~req.sel)
    begin
      irq_q <= 1'b0;
      endint_q <= 1'b0;
    end
    else
    begin
      irq_q <= ~sensor_mode & (fifo_cnt_q != 4'h0) & ~endint_q;
      if (fifo_push)
        endint_q <= 1'b0;
    end
  end
  // Outputs are all registered; scan is low during reset.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      SCAN_OUTPUTS <= 4'h0;
      DISPLAY_PORT_A <= 4'h0;
      DISPLAY_PORT_B <= 4'h0;
      BLANKING_OUTPUT_N <= 1'b0;
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      // Decoded one-of-four or encoded count.
      SCAN_OUTPUTS <= key_mode_q[0] ? 4'(4'h1 << scan_q[1:0]) : scan_q;
      // Blank near digit edges; both blank bits force low.
      BLANKING_OUTPUT_N <= ~((dwell_q < `BLANK_CYCLES) | (&blank_q));
      // Ports show RAM in step with scan while rd_fifo_q is set, blanked apart.
      DISPLAY_PORT_A <= blank_q[1] ? clear_val_q[7:4] : disp_rdata[7:4];
      DISPLAY_PORT_B <= blank_q[0] ? clear_val_q[3:0] : disp_rdata[3:0];
      IRQ <= irq_q;
      DATA_OE <= ~req.cs_n & ~rd_sync_q[1];
      if (rd_start)
        DATA_OUT <= req.sel ? status
          : rd_fifo_q ? fifo_q[fifo_rp_q] : disp_rdata;
    end
  end
  // Reset holds scan low one cycle later.
  a_scan_reset: assert property (@(posedge CLK) RESET |=> SCAN_OUTPUTS == 4'h0)
    else $error("scan not low after reset");
  a_irq_endint: assert property (@(posedge CLK) disable iff (RESET)
    is_cmd && cmd == `CMD_ENDINT |=> !irq_q)
    else $error("end interrupt did not clear");
  a_irq_read: assert property (@(posedge CLK) disable iff (RESET)
    rd_start && !req.sel |=> !irq_q)
    else $error("read did not drop interrupt");
  a_fifo_irq: assert property (@(posedge CLK) disable iff (RESET)
    !sensor_mode && fifo_cnt_q != 4'h0 && !endint_q && !rd_start && !is_cmd
      |=> irq_q)
    else $error("interrupt missing");
  a_fifo_bound: assert property (@(posedge CLK) disable iff (RESET)
    fifo_cnt_q <= 4'h8) else $error("fifo overflow");
  a_cs_gate: assert property (@(posedge CLK) disable iff (RESET)
    CS_N |-> !fifo_pop && !disp_we) else $error("access without cs");
  a_strobe_push: assert property (@(posedge CLK) disable iff (RESET)
    strobe_push && fifo_cnt_q < 4'h8 |=> fifo_cnt_q == $past(fifo_cnt_q) + 4'h1
      || $past(fifo_pop)) else $error("strobe lost");
  a_sensor_control_strobe_input: assert property (@(posedge CLK) disable iff (RESET)
    sensor_mode |-> !strobe_push) else $error("control used in sensor");
endmodule : kbd_scanner

// [kbd_host.sv]
`timescale 1ns/1ps
// Host processor model that runs byte transfers on the parallel port.
module kbd_host
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output kbd_pkg::bus_req_type req,
  output logic rd_n,
  output logic wr_n
);
  // Strobe phases stay well above the three cycles the port needs.
  localparam int HOLD = 6;
  // Idle bus: strobes high and a data byte that is not the last one sent.
  initial
  begin
    req = '{data: 8'h5a, sel: 1'b0, cs_n: 1'b1};
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  // Whole byte write; the device takes it on the strobe rise.
  task automatic wr(input logic sel, input logic [7:0] d);
  begin
    @(negedge clk);
    req = '{data: d, sel: sel, cs_n: 1'b0};
    wr_n = 1'b0;
    repeat (HOLD) @(negedge clk);
    wr_n = 1'b1;
    repeat (HOLD) @(negedge clk);
    req = '{data: ~d, sel: 1'b0, cs_n: 1'b1};
  end
  endtask : wr
  // Byte read; the answer is taken before the strobe is released.
  task automatic rd(input logic cs_n, input logic sel, output logic [7:0] q);
  begin
    @(negedge clk);
    req.cs_n = cs_n;
    req.sel = sel;
    rd_n = 1'b0;
    repeat (HOLD) @(negedge clk);
    q = rdata;
    rd_n = 1'b1;
    repeat (HOLD) @(negedge clk);
    req.cs_n = 1'b1;
  end
  endtask : rd
endmodule : kbd_host

// [keyboard_display_scanner_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
// Self-checking bench: strobed entry, status, display memory, scan.
module keyboard_display_scanner_bench;
  logic CLK = 1'b0;
  logic reset = 1'b1;
  logic [7:0] ret_lines = 8'hff;
  logic control_strobe_input = 1'b0;
  logic shift = 1'b1;
  logic [7:0] data_out;
  logic data_oe;
  logic irq;
  logic [3:0] scan;
  logic [3:0] pa;
  logic [3:0] pb;
  logic blank_n;
  logic rd_n;
  logic wr_n;
  kbd_pkg::bus_req_type bus;
  logic [7:0] q;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  int seed;
  // Half period of 2.5 ns gives the 200 MHz system clock.
  always #2.5 CLK = ~CLK;
  kbd_scanner i_kbd_scanner (.CLK(CLK), .RESET(reset), .CS_N(bus.cs_n),
    .CONTROL_DATA_SELECT(bus.sel), .RD_N(rd_n), .WR_N(wr_n),
    .DATA_IN(bus.data), .DATA_OUT(data_out), .DATA_OE(data_oe), .IRQ(irq),
    .RETURN_LINES(ret_lines), .SHIFT_INPUT(shift),
    .CONTROL_STROBE_INPUT(control_strobe_input), .SCAN_OUTPUTS(scan),
    .DISPLAY_PORT_A(pa), .DISPLAY_PORT_B(pb), .BLANKING_OUTPUT_N(blank_n));
  kbd_host i_kbd_host (.clk(CLK), .rdata(data_out), .req(bus), .rd_n(rd_n),
    .wr_n(wr_n));
  // Low nibble of the status word: full flag over the entry count.
  function automatic logic [3:0] status_of(input int n);
    return {n == 8, 3'(n)};
  endfunction : status_of
  // Prints the counts and the verdict, then stops the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Sixteen cycles of reset; the scan lines are checked low once, at its end.
  task automatic do_reset();
    reset = 1'b1;
    repeat (16) @(negedge CLK);
    `CHK("scan_in_reset", 4'h0, scan)
    reset = 1'b0;
    @(negedge CLK);
  endtask : do_reset
  // One control strobe with a random word on the return lines.
  task automatic push();
    ret_lines = 8'($random(seed));
    if (exp_q.size() < 8)
      exp_q.push_back(ret_lines);
    repeat (4) @(negedge CLK);
    control_strobe_input = 1'b1;
    repeat (4) @(negedge CLK);
    control_strobe_input = 1'b0;
    repeat (6) @(negedge CLK);
  endtask : push
  // Bounded wait for the interrupt line to rise.
  task automatic wait_irq();
    int k;
    for (k = 0; k < 40 && irq !== 1'b1; k++)
      @(negedge CLK);
    `CHK("irq_rise", 1'b1, irq)
    if (irq !== 1'b1)
      close_out();
  endtask : wait_irq
  // Watchdog against a hung handshake.
  initial
  begin
    repeat (100000) @(posedge CLK);
    n_mismatch++;
    close_out();
  end
  // Main sequence.
  initial
  begin
    seed = 32'h9344af2c;
    do_reset();
    i_kbd_host.wr(1'b1, 8'h80);
    i_kbd_host.wr(1'b0, 8'hc5);
    do_reset();
    i_kbd_host.wr(1'b1, 8'h60);
    i_kbd_host.rd(1'b0, 1'b0, q);
    `CHK("ram_kept", 8'hc5, q)
    i_kbd_host.wr(1'b1, 8'h22);
    i_kbd_host.wr(1'b1, 8'h0e);
    i_kbd_host.wr(1'b1, 8'h40);
    push();
    wait_irq();
    repeat (8) push();
    i_kbd_host.rd(1'b0, 1'b1, q);
    `CHK("status_full", status_of(8), q[3:0])
    i_kbd_host.rd(1'b1, 1'b0, q);
    i_kbd_host.rd(1'b0, 1'b1, q);
    `CHK("status_cs", status_of(8), q[3:0])
    for (int i = 0; i < 8; i++)
    begin
      i_kbd_host.rd(1'b0, 1'b0, q);
      `CHK("fifo_word", exp_q[i], q)
      `CHK("irq_after_read", i < 7, irq)
    end
    exp_q.delete();
    push();
    wait_irq();
    i_kbd_host.wr(1'b1, 8'he0);
    repeat (4) @(negedge CLK);
    `CHK("irq_endint", 1'b0, irq)
    i_kbd_host.wr(1'b1, 8'hc2);
    i_kbd_host.wr(1'b1, 8'h0c);
    push();
    `CHK("irq_sensor", 1'b0, irq)
    i_kbd_host.wr(1'b1, 8'h0f);
    for (int i = 0; i < 20; i++)
    begin
      repeat (37) @(negedge CLK);
      if (blank_n === 1'b1)
        `CHK("scan_onehot", 1'b1, $onehot(scan))
    end
    i_kbd_host.wr(1'b1, 8'ha3);
    for (int i = 0; i < 10; i++)
    begin
      repeat (29) @(negedge CLK);
      `CHK("blank_forced", 1'b0, blank_n)
    end
    close_out();
  end
endmodule : keyboard_display_scanner_bench
